// ### verilog/patch_task_pkg.sv
// constants and carrier types for the patch burst download task block
package patch_task_pkg;
	localparam int CLK_HZ = 100000000;
	localparam int TIMEOUT_UNIT_MS = 100;
	localparam int CYCLES_PER_UNIT = CLK_HZ / 1000 * TIMEOUT_UNIT_MS;
	localparam logic [7:0] MODE_REG_OFFSET = 8'h03;
	localparam logic [6:0] INVALID_ADDR = 7'h00;
	localparam int ADDR_LSB = 0;
	localparam int ADDR_MSB = 6;
	localparam int SIZE_LSB = 8;
	localparam int SIZE_MSB = 39;
	localparam int TMO_LSB = 48;
	localparam int TMO_MSB = 53;
	localparam logic [5:0] TMO_RECOMMENDED = 6'h32;
	localparam int PATCH_RAM_DEPTH = 1024;
	localparam int PTR_W = 10;
	// start status codes
	localparam logic [7:0] START_OK = 8'h00;
	localparam logic [7:0] START_BAD_SIZE = 8'h04;
	localparam logic [7:0] START_BAD_ADDR = 8'h05;
	localparam logic [7:0] START_BAD_TMO = 8'h06;
	// standard task return codes
	localparam logic [7:0] RET_OK = 8'h00;
	localparam logic [7:0] RET_REJECT = 8'h03;
	// config failure codes
	localparam logic [7:0] CFAIL_NONE = 8'h00;
	localparam logic [7:0] CFAIL_VERSION = 8'h01;
	localparam logic [7:0] CFAIL_TOO_BIG = 8'h02;
	localparam logic [7:0] CFAIL_CRC = 8'h03;
	localparam logic [7:0] HDR_VERSION_OK = 8'h01;
	// config loader states
	localparam logic [7:0] CST_NODATA = 8'h00;
	localparam logic [7:0] CST_LOAD_I2C = 8'h04;
	localparam logic [7:0] CST_DONE = 8'h05;
	localparam logic [7:0] CST_ERROR = 8'h06;
	localparam logic [7:0] CST_APPLIED = 8'h07;
	localparam logic [7:0] CST_NOT_APPLIED = 8'h08;
	// patch loader states
	localparam logic [7:0] PST_NOPATCH = 8'h00;
	localparam logic [7:0] PST_LOADING = 8'h01;
	localparam logic [7:0] PST_LOADED = 8'h02;
	localparam logic [7:0] PST_RUNNING = 8'h03;
	localparam logic [7:0] PST_ERROR = 8'h06;
	// completion status codes
	localparam logic [7:0] CCS_OK = 8'h00;
	localparam logic [7:0] CCS_WARN = 8'h40;
	localparam logic [7:0] CCS_FAIL = 8'h80;
	localparam logic [7:0] PCS_OK = 8'h00;
	localparam logic [7:0] PCS_NOT_READY = 8'h20;
	localparam logic [7:0] PCS_CODE_CRC = 8'h43;
	localparam logic [7:0] CP_RETURN_OK = 8'h00;
	localparam logic [3:0] NIB_OK = 4'h0;
	localparam logic [3:0] NIB_WARN = 4'h4;
	localparam logic [3:0] NIB_ERR = 4'h8;
	localparam int VALID_FLAG_ONE = 1;
	localparam logic [7:0] FLAG_ONE = 8'h01;
	localparam logic [7:0] FLAG_ZERO = 8'h00;
	localparam logic [31:0] CRC_POLY = 32'h04c11db7;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;

	typedef enum logic [3:0] {
		TASK_NONE = 4'h0,
		TASK_START = 4'h1,
		TASK_COMPLETE = 4'h2,
		TASK_EXIT = 4'h3,
		TASK_GO_PATCH = 4'h4
	} task_code_type;

	typedef struct packed {
		logic [31:0] calc_crc;
		logic [31:0] xfer_crc;
		logic [15:0] data_size;
		logic [7:0] hdr_version;
		logic [7:0] fail_code;
		logic [7:0] cfg_state;
		logic [7:0] cfg_valid;
		logic [7:0] patch_state;
		logic [7:0] patch_valid;
		logic [7:0] cfg_status;
		logic [7:0] patch_status;
		logic [7:0] cp_return;
		logic [3:0] patch_nibble;
		logic [3:0] cfg_nibble;
	} complete_report_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} burst_byte_type;
endpackage

// ### verilog/patch_crc32.sv
// byte-wise crc32 accumulator over the burst stream
`timescale 1ns/1ps
module patch_crc32 (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic clear_i,
	input wire logic byte_en_i,
	input wire logic [7:0] byte_i,
	output logic [31:0] crc_o
);
	import patch_task_pkg::*;

	logic [31:0] crc_q;
	logic [31:0] crc_d;

	function automatic logic [31:0] crc_step(input logic [31:0] c,
			input logic [7:0] b);
		logic [31:0] r;
		logic [31:0] p;
		// reflected form, as the stream is shifted lsb first
		p = {<<{CRC_POLY}};
		r = c ^ {24'h000000, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ p) : (r >> 1);
		end
		return r;
	endfunction

	always_comb begin
		crc_d = crc_q;
		if (clear_i) begin
			crc_d = CRC_INIT;
		end else if (byte_en_i) begin
			crc_d = crc_step(crc_q, byte_i);
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			crc_q <= CRC_INIT;
		end else if (ce_i) begin
			crc_q <= crc_d;
		end
	end

	assign crc_o = ~crc_q;
endmodule // patch_crc32

// ### verilog/patch_burst_download_tasks.sv
// command interpreter for the patch burst download tasks
// Overview of operation
// - bundle address in bits 6:0; zero or strap-selected address is invalid
// - bundle size bytes 15:8 low to 39:32 high form one value
// - start status: 0 ok, 04 size, 05 address, 06 timeout invalid
// - start done once status is out; rejected in application mode
// - successful start moves secondary target address to bundle address
// - start task accepted only from the host target port
// - repeated start ignores data, restarts timer, rewinds write pointer
// - completion after all data; crc check, then patch init on pass
// - config failure code: none, version, too big, crc mismatch
// - config loader state codes 0x00 through 0x08
// - config and patch valid flags read one when content was valid
// - patch loader state codes 0x00 through 0x06
// - config completion status: 00 ok, 40 warning, 80 failure
// - patch completion status always valid, codes 00 to 45
// - config processing return always reports success
// - first byte holds patch and config return nibbles
// - completion restores address; success enters application mode
// - exit restores strap address, stays in patch mode; rejected in app
// - return-to-patch sets patch mode and disables phy when allowed
// - after return-to-patch, ready-for-patch event tells host to push
// - six-bit nonzero timeout in 100 ms units
`timescale 1ns/1ps
module patch_burst_download_tasks #(
	parameter int UNIT_CYCLES = patch_task_pkg::CYCLES_PER_UNIT,
	parameter logic [15:0] SRAM_BYTES = 16'h0400
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic task_valid_i,
	input wire patch_task_pkg::task_code_type task_code_i,
	input wire logic from_host_port_i,
	input wire logic [63:0] task_data_i,
	input wire logic [6:0] strap_addr_i,
	input wire logic high_voltage_strap_option_i,
	input wire logic patched_over_i2c_i,
	input wire patch_task_pkg::burst_byte_type burst_i,
	output logic task_busy_o,
	output logic task_done_o,
	output logic [7:0] task_return_o,
	output patch_task_pkg::complete_report_type report_o,
	output logic [6:0] target_addr_o,
	output logic app_mode_o,
	output logic phy_disable_o,
	output logic patch_ready_event_o,
	output logic patch_init_o,
	output logic burst_active_o,
	output logic burst_timeout_o
);
	import patch_task_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_EXEC = 4'b0010,
		ST_CHECK = 4'b0100,
		ST_DONE = 4'b1000
	} state_type;

	state_type state_q, state_d;
	task_code_type code_q, code_d;
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic [7:0] ret_q, ret_d;
	complete_report_type rep_q, rep_d;
	logic [6:0] addr_q, addr_d;
	logic [6:0] bund_addr_q, bund_addr_d;
	logic app_q, app_d;
	logic phy_off_q, phy_off_d;
	logic ready_ev_q, ready_ev_d;
	logic init_q, init_d;
	logic burst_q, burst_d;
	logic tmo_ev_q, tmo_ev_d;
	logic [31:0] size_q, size_d;
	logic [5:0] tmo_q, tmo_d;
	logic [5:0] units_q, units_d;
	logic [31:0] tick_q, tick_d;
	logic [PTR_W-1:0] wptr_q, wptr_d;
	logic [31:0] rcount_q, rcount_d;
	logic [2:0] addr_taken_q;
	logic [7:0] ram [PATCH_RAM_DEPTH];
	logic crc_clear;
	logic byte_en;
	logic [31:0] crc_val;

	// strap pins are slow and asynchronous
	logic [6:0] strap_m_q, strap_s_q;
	logic hv_m_q, hv_s_q;

	function automatic logic addr_invalid(input logic [6:0] a,
			input logic [6:0] strap);
		return (a == INVALID_ADDR) || (a == strap);
	endfunction

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strap_m_q <= 7'h00;
			strap_s_q <= 7'h00;
			hv_m_q <= 1'b0;
			hv_s_q <= 1'b0;
		end else if (ce_i) begin
			strap_m_q <= strap_addr_i;
			strap_s_q <= strap_m_q;
			hv_m_q <= high_voltage_strap_option_i;
			hv_s_q <= hv_m_q;
		end
	end

	// address loads and tasks open only once the strap sync has filled
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_taken_q <= 3'h0;
		end else if (ce_i) begin
			addr_taken_q <= {addr_taken_q[1:0], 1'b1};
		end
	end

	assign byte_en = burst_q && burst_i.valid;

	patch_crc32 u_crc (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.clear_i(crc_clear),
		.byte_en_i(byte_en),
		.byte_i(burst_i.data),
		.crc_o(crc_val)
	);

	always_comb begin
		state_d = state_q;
		code_d = code_q;
		busy_d = busy_q;
		done_d = 1'b0;
		ret_d = ret_q;
		rep_d = rep_q;
		addr_d = addr_taken_q[2] ? addr_q : strap_s_q;
		bund_addr_d = bund_addr_q;
		app_d = app_q;
		phy_off_d = phy_off_q;
		ready_ev_d = 1'b0;
		init_d = 1'b0;
		burst_d = burst_q;
		tmo_ev_d = 1'b0;
		size_d = size_q;
		tmo_d = tmo_q;
		units_d = units_q;
		tick_d = tick_q;
		wptr_d = wptr_q;
		rcount_d = rcount_q;
		crc_clear = 1'b0;
		// burst timer in 100 ms units
		if (burst_q) begin
			if (tick_q >= UNIT_CYCLES - 1) begin
				tick_d = 32'h00000000;
				if (units_q >= tmo_q - 6'h01) begin
					burst_d = 1'b0;
					tmo_ev_d = 1'b1;
					addr_d = strap_s_q;
				end else begin
					units_d = units_q + 6'h01;
				end
			end else begin
				tick_d = tick_q + 32'h00000001;
			end
		end
		if (byte_en) begin
			wptr_d = wptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
			rcount_d = rcount_q + 32'h00000001;
		end
		case (state_q)
			ST_IDLE: begin
				if (task_valid_i && task_code_i != TASK_NONE
						&& addr_taken_q[2]) begin
					code_d = task_code_i;
					busy_d = 1'b1;
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				state_d = ST_DONE;
				case (code_q)
					TASK_START: begin
						if (app_q || !from_host_port_i) begin
							ret_d = RET_REJECT;
						end else if (burst_q) begin
							// repeat: ignore new task data, restart timer
							tick_d = 32'h00000000;
							units_d = 6'h00;
							wptr_d = '0;
							rcount_d = 32'h00000000;
							crc_clear = 1'b1;
							ret_d = START_OK;
						end else if (task_data_i[SIZE_MSB:SIZE_LSB]
								== 32'h00000000) begin
							ret_d = START_BAD_SIZE;
						end else if (addr_invalid(
								task_data_i[ADDR_MSB:ADDR_LSB],
								strap_s_q)) begin
							ret_d = START_BAD_ADDR;
						end else if (task_data_i[TMO_MSB:TMO_LSB]
								== 6'h00) begin
							ret_d = START_BAD_TMO;
						end else begin
							size_d = task_data_i[SIZE_MSB:SIZE_LSB];
							tmo_d = task_data_i[TMO_MSB:TMO_LSB];
							bund_addr_d = task_data_i[ADDR_MSB:ADDR_LSB];
							addr_d = task_data_i[ADDR_MSB:ADDR_LSB];
							burst_d = 1'b1;
							tick_d = 32'h00000000;
							units_d = 6'h00;
							wptr_d = '0;
							rcount_d = 32'h00000000;
							crc_clear = 1'b1;
							rep_d.patch_state = PST_LOADING;
							rep_d.cfg_state = CST_LOAD_I2C;
							ret_d = START_OK;
						end
					end
					TASK_COMPLETE: begin
						if (app_q) begin
							ret_d = RET_REJECT;
						end else begin
							burst_d = 1'b0;
							addr_d = strap_s_q;
							state_d = ST_CHECK;
						end
					end
					TASK_EXIT: begin
						if (app_q) begin
							ret_d = RET_REJECT;
						end else begin
							burst_d = 1'b0;
							addr_d = strap_s_q;
							ret_d = RET_OK;
						end
					end
					TASK_GO_PATCH: begin
						if (!app_q || !hv_s_q || patched_over_i2c_i) begin
							ret_d = RET_REJECT;
						end else begin
							app_d = 1'b0;
							phy_off_d = 1'b1;
							ready_ev_d = 1'b1;
							ret_d = RET_OK;
						end
					end
					default: begin
						ret_d = RET_REJECT;
					end
				endcase
			end
			ST_CHECK: begin
				state_d = ST_DONE;
				rep_d.calc_crc = crc_val;
				rep_d.xfer_crc = size_q; // crc carried in the start size word
				rep_d.data_size = rcount_q[15:0];
				rep_d.hdr_version = HDR_VERSION_OK;
				rep_d.cp_return = CP_RETURN_OK;
				if (rcount_q[15:0] > SRAM_BYTES) begin
					rep_d.fail_code = CFAIL_TOO_BIG;
				end else if (crc_val != size_q) begin
					rep_d.fail_code = CFAIL_CRC;
				end else begin
					rep_d.fail_code = CFAIL_NONE;
				end
				if (rcount_q[15:0] <= SRAM_BYTES && crc_val == size_q) begin
					rep_d.cfg_state = CST_APPLIED;
					rep_d.cfg_valid = FLAG_ONE;
					rep_d.patch_valid = FLAG_ONE;
					rep_d.patch_state = PST_RUNNING;
					rep_d.cfg_status = CCS_OK;
					rep_d.patch_status = PCS_OK;
					rep_d.patch_nibble = NIB_OK;
					rep_d.cfg_nibble = NIB_OK;
					init_d = 1'b1;
					app_d = 1'b1;
					ret_d = RET_OK;
				end else begin
					rep_d.cfg_state = CST_NOT_APPLIED;
					rep_d.cfg_valid = FLAG_ZERO;
					rep_d.patch_valid = FLAG_ZERO;
					rep_d.patch_state = PST_ERROR;
					rep_d.cfg_status = CCS_FAIL;
					rep_d.patch_status = PCS_CODE_CRC;
					rep_d.patch_nibble = NIB_ERR;
					rep_d.cfg_nibble = NIB_ERR;
					ret_d = {NIB_ERR, NIB_ERR};
				end
			end
			ST_DONE: begin
				busy_d = 1'b0;
				done_d = 1'b1;
				code_d = TASK_NONE;
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
				busy_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (ce_i && byte_en) begin
			ram[wptr_q] <= burst_i.data;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= ST_IDLE;
			code_q <= TASK_NONE;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			ret_q <= 8'h00;
			rep_q <= '{cfg_state: CST_NODATA, patch_state: PST_NOPATCH,
				patch_status: PCS_NOT_READY, cp_return: CP_RETURN_OK,
				default: '0};
			addr_q <= 7'h00;
			bund_addr_q <= 7'h00;
			app_q <= 1'b0;
			phy_off_q <= 1'b0;
			ready_ev_q <= 1'b0;
			init_q <= 1'b0;
			burst_q <= 1'b0;
			tmo_ev_q <= 1'b0;
			size_q <= 32'h00000000;
			tmo_q <= TMO_RECOMMENDED;
			units_q <= 6'h00;
			tick_q <= 32'h00000000;
			wptr_q <= '0;
			rcount_q <= 32'h00000000;
		end else if (ce_i) begin
			state_q <= state_d;
			code_q <= code_d;
			busy_q <= busy_d;
			done_q <= done_d;
			ret_q <= ret_d;
			rep_q <= rep_d;
			addr_q <= addr_d;
			bund_addr_q <= bund_addr_d;
			app_q <= app_d;
			phy_off_q <= phy_off_d;
			ready_ev_q <= ready_ev_d;
			init_q <= init_d;
			burst_q <= burst_d;
			tmo_ev_q <= tmo_ev_d;
			size_q <= size_d;
			tmo_q <= tmo_d;
			units_q <= units_d;
			tick_q <= tick_d;
			wptr_q <= wptr_d;
			rcount_q <= rcount_d;
		end
	end

	assign task_busy_o = busy_q;
	assign task_done_o = done_q;
	assign task_return_o = ret_q;
	assign report_o = rep_q;
	assign target_addr_o = addr_q;
	assign app_mode_o = app_q;
	assign phy_disable_o = phy_off_q;
	assign patch_ready_event_o = ready_ev_q;
	assign patch_init_o = init_q;
	assign burst_active_o = burst_q;
	assign burst_timeout_o = tmo_ev_q;
endmodule // patch_burst_download_tasks

// ### verif/patch_task_assertions.sv
// port-level checks for the patch burst download task block
`timescale 1ns/1ps
module patch_task_checker (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic task_valid_i,
	input wire patch_task_pkg::task_code_type task_code_i,
	input wire logic from_host_port_i,
	input wire logic [63:0] task_data_i,
	input wire logic [6:0] strap_addr_i,
	input wire logic task_busy_o,
	input wire logic task_done_o,
	input wire logic [7:0] task_return_o,
	input wire patch_task_pkg::complete_report_type report_o,
	input wire logic [6:0] target_addr_o,
	input wire logic app_mode_o,
	input wire logic phy_disable_o,
	input wire logic burst_active_o
);
	import patch_task_pkg::*;
	logic take;
	logic start;
	logic [1:0] up_q;
	// the block ignores tasks until its strap synchroniser has filled
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			up_q <= 2'h0;
		end else if (ce_i && up_q != 2'h3) begin
			up_q <= up_q + 2'h1;
		end
	end
	// idle whenever busy is low, done pulse or not
	assign take = task_valid_i && !task_busy_o && up_q == 2'h3
		&& task_code_i != TASK_NONE;
	assign start = take && task_code_i == TASK_START;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i || !ce_i);
	a_task_timing: assert property (
		take && (task_code_i != TASK_COMPLETE || app_mode_o)
		|=> task_busy_o ##1
		task_busy_o ##1 (!task_busy_o && task_done_o))
		else $error("short task out of step");
	a_complete_timing: assert property (
		take && task_code_i == TASK_COMPLETE && !app_mode_o
		|=> task_busy_o[*3] ##1 (!task_busy_o && task_done_o))
		else $error("completion task out of step");
	a_addr_invalid: assert property (
		start && !burst_active_o && (task_data_i[6:0] == INVALID_ADDR
		|| task_data_i[6:0] == strap_addr_i) |-> ##3
		task_return_o != START_OK) else $error("bad address taken");
	a_tmo_invalid: assert property (
		start && !burst_active_o && task_data_i[53:48] == 6'h00
		|-> ##3 task_return_o != START_OK)
		else $error("zero timeout taken");
	a_port_only: assert property (
		start && !from_host_port_i |-> ##3 task_return_o != START_OK)
		else $error("start taken from other port");
	a_new_address: assert property (
		start && !burst_active_o ##3 task_return_o == START_OK
		|-> target_addr_o == 7'($past(task_data_i, 3)))
		else $error("bundle address not applied");
	a_exit_restore: assert property (
		take && task_code_i == TASK_EXIT ##3 task_return_o == RET_OK
		|-> target_addr_o == strap_addr_i && !app_mode_o)
		else $error("exit left wrong address or mode");
	a_go_patch: assert property (
		take && task_code_i == TASK_GO_PATCH ##3 task_return_o == RET_OK
		|-> phy_disable_o && !app_mode_o)
		else $error("return to patch incomplete");
	a_cp_return: assert property (
		take && task_code_i == TASK_COMPLETE
		|-> ##4 report_o.cp_return == CP_RETURN_OK)
		else $error("processing return not success");
	c_start_ok: cover property (start ##3 task_return_o == START_OK);
	c_complete: cover property (take && task_code_i == TASK_COMPLETE);
	c_exit: cover property (take && task_code_i == TASK_EXIT);
endmodule // patch_task_checker

bind patch_burst_download_tasks patch_task_checker i_chk (.ref_clk_i,
	.nrst_i, .ce_i, .task_valid_i, .task_code_i, .from_host_port_i,
	.task_data_i, .strap_addr_i, .task_busy_o, .task_done_o,
	.task_return_o, .report_o, .target_addr_o, .app_mode_o,
	.phy_disable_o, .burst_active_o);

// ### verif/host_burst_model.sv
// host model pushing burst bytes to the secondary address
`timescale 1ns/1ps
module host_burst_model (
	input wire logic ref_clk_i,
	input wire logic go_i,
	input wire logic [7:0] count_i,
	input wire logic slow_i,
	output patch_task_pkg::burst_byte_type burst_o,
	output logic idle_o
);
	import patch_task_pkg::*;
	logic [7:0] left = 8'h00;
	logic gap = 1'b0;
	initial burst_o = '{valid: 1'b0, data: 8'h5a};
	// slow mode stalls every other cycle
	always @(posedge ref_clk_i) begin
		gap <= slow_i && !gap;
		if (left != 8'h00 && !gap) begin
			// bytes numbered from one, in order
			burst_o <= '{valid: 1'b1, data: count_i - left + 8'h01};
			left <= left - 8'h01;
		end else begin
			// idle data inverts so stale bytes never look valid
			burst_o <= '{valid: 1'b0, data: ~burst_o.data};
			if (go_i) begin
				left <= count_i;
			end
		end
	end
	assign idle_o = left == 8'h00;
endmodule // host_burst_model

// ### verif/patch_burst_download_tasks_bench.sv
// self-checking bench for the patch burst download task block
`timescale 1ns/1ps
module patch_burst_download_tasks_bench;
	import patch_task_pkg::*;
	localparam logic [6:0] STRAP = 7'h20;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic task_valid_i = 1'b0;
	task_code_type task_code_i = TASK_NONE;
	logic host = 1'b1;
	logic [63:0] task_data_i = '0;
	logic go = 1'b0;
	logic slow = 1'b1;
	logic [7:0] count = 8'h08;
	burst_byte_type burst;
	complete_report_type rep;
	logic [7:0] ret;
	logic [6:0] addr;
	logic idle, busy, done, app, phy, active, tmo;
	logic ce = 1'b1;
	logic i2c = 1'b0;
	logic init, ready;
	int inits = 0;
	int readies = 0;
	int failures = 0;
	int check_count = 0;

	patch_burst_download_tasks #(.UNIT_CYCLES(4)) i_dut (.ref_clk_i,
		.nrst_i, .ce_i(ce), .task_valid_i, .task_code_i,
		.from_host_port_i(host), .task_data_i, .strap_addr_i(STRAP),
		.high_voltage_strap_option_i(1'b1), .patched_over_i2c_i(i2c),
		.burst_i(burst), .task_busy_o(busy), .task_done_o(done),
		.task_return_o(ret), .report_o(rep), .target_addr_o(addr),
		.app_mode_o(app), .phy_disable_o(phy),
		.patch_ready_event_o(ready), .patch_init_o(init),
		.burst_active_o(active), .burst_timeout_o(tmo));
	host_burst_model i_host (.ref_clk_i, .go_i(go), .count_i(count),
		.slow_i(slow), .burst_o(burst), .idle_o(idle));

	initial forever #5 ref_clk_i = ~ref_clk_i;

	// one-cycle pulses are counted so that later checks need not race them
	always @(negedge ref_clk_i) begin
		if (init === 1'b1) begin
			inits++;
		end
		if (ready === 1'b1) begin
			readies++;
		end
	end

	// reflected crc32 over bytes 1..n, as the host model sends them
	function automatic logic [31:0] crc_of(input int n);
		logic [31:0] c;
		logic [31:0] p;
		for (int j = 0; j < 32; j++) begin
			p[j] = CRC_POLY[31 - j];
		end
		c = CRC_INIT;
		for (int k = 1; k <= n; k++) begin
			for (int i = 0; i < 8; i++) begin
				c = (c[0] ^ k[i]) ? ((c >> 1) ^ p) : (c >> 1);
			end
		end
		return ~c;
	endfunction

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic wait_high(ref logic flag, input int limit);
		int n;
		n = 0;
		while (flag !== 1'b1 && n < limit) begin
			@(negedge ref_clk_i);
			n++;
		end
		if (flag !== 1'b1) begin
			failures++;
			give_verdict();
		end
	endtask

	// result is read only once done shows
	task automatic run(input task_code_type code, input logic [63:0] d,
		input logic [7:0] exp);
		task_valid_i = 1'b1;
		task_code_i = code;
		task_data_i = d;
		@(negedge ref_clk_i);
		task_valid_i = 1'b0;
		wait_high(done, 8);
		check("task return", ret, exp);
	endtask

	task automatic start(input logic [5:0] t, input logic [31:0] s,
		input logic [6:0] a, input logic [7:0] exp);
		run(TASK_START, {10'h000, t, 8'h00, s, 1'b0, a}, exp);
	endtask

	task automatic push(input logic [7:0] n);
		count = n;
		go = 1'b1;
		@(negedge ref_clk_i);
		go = 1'b0;
		@(negedge ref_clk_i);
		wait_high(idle, 64);
	endtask

	initial begin
		repeat (10) @(negedge ref_clk_i);
		nrst_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		check("strap address", addr, STRAP);
		start(6'h32, 32'h10, 7'h00, START_BAD_ADDR);
		start(6'h32, 32'h10, STRAP, START_BAD_ADDR);
		start(6'h00, 32'h10, 7'h41, START_BAD_TMO);
		start(6'h32, 32'h0, 7'h41, START_BAD_SIZE);
		host = 1'b0;
		start(6'h32, 32'h10, 7'h41, RET_REJECT);
		host = 1'b1;
		start(6'h32, 32'h10, 7'h41, START_OK);
		check("bundle address", addr, 7'h41);
		check("burst on", active, 1'b1);
		push(8'h08);
		// repeat with bad data must still succeed and keep the address
		start(6'h00, 32'h0, 7'h00, START_OK);
		check("kept address", addr, 7'h41);
		run(TASK_EXIT, '0, RET_OK);
		check("exit address", addr, STRAP);
		check("exit mode", app, 1'b0);
		start(6'h32, 32'h10, 7'h43, START_OK);
		slow = 1'b0;
		push(8'h10);
		run(TASK_COMPLETE, '0, 8'h88);
		check("config status", rep.cfg_status, CCS_FAIL);
		check("cp return", rep.cp_return, CP_RETURN_OK);
		check("config valid", rep.cfg_valid, FLAG_ZERO);
		check("fail code crc", rep.fail_code, CFAIL_CRC);
		check("restored address", addr, STRAP);
		check("mode after fail", app, 1'b0);
		run(TASK_GO_PATCH, '0, RET_REJECT);
		check("phy", phy, 1'b0);
		// good bundle: the size word carries the crc of bytes 1..4
		start(6'h32, crc_of(4), 7'h45, START_OK);
		push(8'h04);
		run(TASK_COMPLETE, '0, RET_OK);
		check("computed crc", rep.calc_crc, crc_of(4));
		check("data size", rep.data_size, 32'h4);
		check("fail code", rep.fail_code, CFAIL_NONE);
		check("patch state", rep.patch_state, PST_RUNNING);
		check("patch valid", rep.patch_valid, FLAG_ONE);
		check("patch status", rep.patch_status, PCS_OK);
		check("app mode", app, 1'b1);
		check("init pulses", inits, 1);
		run(TASK_COMPLETE, '0, RET_REJECT);
		run(TASK_EXIT, '0, RET_REJECT);
		start(6'h32, 32'h10, 7'h46, RET_REJECT);
		i2c = 1'b1;
		run(TASK_GO_PATCH, '0, RET_REJECT);
		i2c = 1'b0;
		run(TASK_GO_PATCH, '0, RET_OK);
		check("phy off", phy, 1'b1);
		check("patch mode", app, 1'b0);
		check("ready events", readies, 1);
		start(6'h01, 32'h10, 7'h44, START_OK);
		// a low clock enable must hold the burst timer too
		ce = 1'b0;
		repeat (8) @(negedge ref_clk_i);
		check("frozen burst", active, 1'b1);
		ce = 1'b1;
		wait_high(tmo, 20);
		@(negedge ref_clk_i);
		check("timeout address", addr, STRAP);
		check("timeout burst", active, 1'b0);
		give_verdict();
	end
endmodule // patch_burst_download_tasks_bench
